// ==== src/cst_pkg.sv ====
// constants shared by the conditional skip test decoder and its core
package cst_pkg;

    // ------------------------------------------------------------
    // instruction word geometry
    // ------------------------------------------------------------
    localparam int        CST_INSTR_W   = 10;
    localparam int        CST_NUM_TESTS = 4;

    // ------------------------------------------------------------
    // opcodes of the four single-word skip tests
    // ------------------------------------------------------------
    localparam logic [9:0] CST_OP_EXT0_FLAG = 10'h038;   // skip_on_ext0_flag
    localparam logic [9:0] CST_OP_CONV_DONE = 10'h287;   // skip_on_conversion_done
    localparam logic [9:0] CST_OP_PORT_BIT  = 10'h289;   // skip_on_one_bit_port
    localparam logic [9:0] CST_OP_PIN_LEVEL = 10'h03A;   // skip_on_irq_pin_level

    // ------------------------------------------------------------
    // position of each test in the one-hot hit vector
    // ------------------------------------------------------------
    localparam int CST_IDX_EXT0 = 0;
    localparam int CST_IDX_CONV = 1;
    localparam int CST_IDX_PORT = 2;
    localparam int CST_IDX_PIN  = 3;

    // opcode table indexed by the positions above
    localparam logic [3:0][9:0] CST_OPCODES = {CST_OP_PIN_LEVEL, CST_OP_PORT_BIT,
                                               CST_OP_CONV_DONE, CST_OP_EXT0_FLAG};

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic CST_FLAG_RST = 1'b0;
    localparam logic CST_SKIP_RST = 1'b0;

endpackage

// ==== src/cst_dec_if.sv ====
// carrier between the core and its opcode decoder
`timescale 1ns/10ps
interface cst_dec_if;
    logic [cst_pkg::CST_INSTR_W-1:0]   instr;  // instruction word under decode
    logic [cst_pkg::CST_NUM_TESTS-1:0] hit;    // one-hot match per skip test

    modport dec  (input instr, output hit);
    modport core (output instr, input hit);
endinterface

// ==== src/cst_decoder.sv ====
// opcode matcher for the four skip tests
`timescale 1ns/10ps
module cst_decoder (
    cst_dec_if.dec dif    // instruction in, one-hot hit out
);

    // ------------------------------------------------------------
    // one comparator per test opcode
    // ------------------------------------------------------------
    for (genvar g = 0; g < cst_pkg::CST_NUM_TESTS; g++) begin : g_match
        // full ten-bit compare, so neighbouring opcodes never alias
        assign dif.hit[g] = (dif.instr == cst_pkg::CST_OPCODES[g]);
    end

endmodule

// ==== src/cst_skip_core.sv ====
// execution of the four conditional skip test instructions
`timescale 1ns/10ps
module cst_skip_core #(
    parameter int INSTR_W = 10                       // instruction word width
) (
    input  wire logic               clk,                      // instruction clock, 50 MHz
    input  wire logic               sys_rst,                  // async reset, active high
    input  wire logic               instr_valid,              // one instruction issued this cycle
    input  wire logic [INSTR_W-1:0] instr,                    // issued instruction word
    input  wire logic               ext0_event,               // pulse: external 0 request
    input  wire logic               conversion_event,         // pulse: conversion finished
    input  wire logic               ext0_irq_enable_bit,      // ext0 interrupt enable
    input  wire logic               converter_irq_enable_bit, // converter interrupt enable
    input  wire logic               irq_pin_polarity_bit,     // pin level compared against
    input  wire logic               irq_pin_level,            // interrupt pin, synchronous
    input  wire logic               one_bit_port,             // one-bit output port value
    output logic                    exec_enable,              // issued word may take effect
    output logic                    skip_pending,             // next word will be suppressed
    output logic                    ext0_request_flag,        // ext0 request flag
    output logic                    conversion_done_flag      // conversion completion flag
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (INSTR_W != cst_pkg::CST_INSTR_W) begin : g_bad_width
        $error("cst_skip_core: instruction width must be ten bits");
    end

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    cst_dec_if dif ();

    assign dif.instr = instr;

    cst_decoder u_dec (
        .dif (dif.dec)
    );

    logic exec_ok;    // issued and not suppressed
    logic do_ext0;    // ext0 flag test executes
    logic do_conv;    // conversion test executes
    logic do_port;    // port test executes
    logic do_pin;     // pin test executes
    logic take_ext0;  // ext0 test skips
    logic take_conv;  // conversion test skips
    logic take_port;  // port test skips
    logic take_pin;   // pin test skips

    // a suppressed word executes nothing, so it cannot start a skip either
    assign exec_ok     = instr_valid & ~skip_pending;
    assign exec_enable = exec_ok;

    // per-test execute strobes
    assign do_ext0 = exec_ok & dif.hit[cst_pkg::CST_IDX_EXT0];
    assign do_conv = exec_ok & dif.hit[cst_pkg::CST_IDX_CONV];
    assign do_port = exec_ok & dif.hit[cst_pkg::CST_IDX_PORT];
    assign do_pin  = exec_ok & dif.hit[cst_pkg::CST_IDX_PIN];

    // ------------------------------------------------------------
    // skip conditions
    // ------------------------------------------------------------
    // flag tests turn into no-operations while their interrupt is enabled
    assign take_ext0 = do_ext0 & ~ext0_irq_enable_bit & ext0_request_flag;
    assign take_conv = do_conv & ~converter_irq_enable_bit & conversion_done_flag;
    assign take_port = do_port & one_bit_port;
    // pin skips when its level equals the polarity bit
    assign take_pin  = do_pin & (irq_pin_level == irq_pin_polarity_bit);

    // ------------------------------------------------------------
    // next-state logic for skip latch and flags
    // ------------------------------------------------------------
    logic next_skip_pending;
    logic next_ext0_request_flag;
    logic next_conversion_done_flag;

    // set wins over clear, so a request arriving on a taken skip is kept
    always_comb begin
        next_skip_pending         = skip_pending;
        next_ext0_request_flag    = ext0_request_flag;
        next_conversion_done_flag = conversion_done_flag;
        if (instr_valid) begin
            // one word consumes or arms the suppression
            next_skip_pending = take_ext0 | take_conv | take_port | take_pin;
        end
        if (take_ext0) begin
            next_ext0_request_flag = 1'b0;
        end
        if (ext0_event) begin
            next_ext0_request_flag = 1'b1;
        end
        if (take_conv) begin
            next_conversion_done_flag = 1'b0;
        end
        if (conversion_event) begin
            next_conversion_done_flag = 1'b1;
        end
    end

    // registers only; no logic here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            skip_pending         <= cst_pkg::CST_SKIP_RST;
            ext0_request_flag    <= cst_pkg::CST_FLAG_RST;
            conversion_done_flag <= cst_pkg::CST_FLAG_RST;
        end else begin
            skip_pending         <= next_skip_pending;
            ext0_request_flag    <= next_ext0_request_flag;
            conversion_done_flag <= next_conversion_done_flag;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // taken ext0 test arms skip and clears the flag unless re-requested
    a_ext0_skip_clear: assert property (
        (instr_valid && !skip_pending && dif.hit[cst_pkg::CST_IDX_EXT0]
         && !ext0_irq_enable_bit && ext0_request_flag)
        |=> skip_pending && (ext0_request_flag == $past(ext0_event))
    ) else $error("ext0 test did not skip and clear");

    // ext0 flag falls only through a taken ext0 test
    a_ext0_fall_cause: assert property (
        $fell(ext0_request_flag) |-> $past(take_ext0)
    ) else $error("ext0 flag cleared without a taken test");

    // enabled ext0 test behaves as no-operation
    a_ext0_nop_hold: assert property (
        (instr_valid && !skip_pending && dif.hit[cst_pkg::CST_IDX_EXT0] && ext0_irq_enable_bit)
        |=> !skip_pending && (ext0_request_flag == ($past(ext0_request_flag) || $past(ext0_event)))
    ) else $error("enabled ext0 test was not a no-operation");

    // taken conversion test arms skip and clears the flag
    a_conv_skip_clear: assert property (
        (instr_valid && !skip_pending && dif.hit[cst_pkg::CST_IDX_CONV]
         && !converter_irq_enable_bit && conversion_done_flag)
        |=> skip_pending && (conversion_done_flag == $past(conversion_event))
    ) else $error("conversion test did not skip and clear");

    // enabled conversion test behaves as no-operation
    a_conv_nop_hold: assert property (
        (instr_valid && !skip_pending && dif.hit[cst_pkg::CST_IDX_CONV] && converter_irq_enable_bit)
        |=> !skip_pending
            && (conversion_done_flag == ($past(conversion_done_flag) || $past(conversion_event)))
    ) else $error("enabled conversion test was not a no-operation");

    // port test follows the port bit
    a_port_skip_value: assert property (
        (instr_valid && !skip_pending && dif.hit[cst_pkg::CST_IDX_PORT])
        |=> skip_pending == $past(one_bit_port)
    ) else $error("port test skip does not match port");

    // pin test compares level with polarity
    a_pin_skip_level: assert property (
        (instr_valid && !skip_pending && dif.hit[cst_pkg::CST_IDX_PIN])
        |=> skip_pending == ($past(irq_pin_level) == $past(irq_pin_polarity_bit))
    ) else $error("pin test skip does not match pin level");

    // suppressed word has no effect and ends the suppression
    a_skip_suppress: assert property (
        (skip_pending && instr_valid)
        |-> !exec_enable ##1 (!skip_pending && !$fell(ext0_request_flag) && !$fell(conversion_done_flag))
    ) else $error("suppressed word took effect");

    // suppression waits for the next issued word
    a_skip_waits: assert property (
        (skip_pending && !instr_valid) |=> skip_pending
    ) else $error("skip lost before next word");

    // conversion flag falls only through a taken conversion test
    a_conv_fall_cause: assert property (
        $fell(conversion_done_flag) |-> $past(take_conv)
    ) else $error("conversion flag cleared without a taken test");

    // a request in the cycle of a taken ext0 test survives the clear
    a_ext0_set_wins: assert property (
        ext0_event |=> ext0_request_flag
    ) else $error("ext0 request lost against a clear");

    // a completion in the cycle of a taken conversion test survives the clear
    a_conv_set_wins: assert property (
        conversion_event |=> conversion_done_flag
    ) else $error("conversion completion lost against a clear");

    // no skip test ever sets the ext0 flag; only its request does
    a_ext0_rise_cause: assert property (
        $rose(ext0_request_flag) |-> $past(ext0_event)
    ) else $error("ext0 flag set without a request");

    // no skip test ever sets the conversion flag; only completion does
    a_conv_rise_cause: assert property (
        $rose(conversion_done_flag) |-> $past(conversion_event)
    ) else $error("conversion flag set without a completion");

    // suppression is armed only by a word that really executed
    a_skip_rise_cause: assert property (
        $rose(skip_pending) |-> $past(exec_ok)
    ) else $error("skip armed by a suppressed or missing word");

    // an executed word that is none of the tests never arms a skip
    a_nonmatch_clears: assert property (
        (instr_valid && !skip_pending && !(|dif.hit)) |=> !skip_pending
    ) else $error("unrelated word armed a skip");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_ext0_taken:   cover property (take_ext0 ##1 (instr_valid && !exec_enable));
    c_conv_taken:   cover property (take_conv && conversion_event);
    c_port_skip:    cover property (take_port);
    c_pin_high:     cover property (take_pin && irq_pin_polarity_bit);
    c_ext0_nop:     cover property (do_ext0 && ext0_irq_enable_bit && ext0_request_flag);

endmodule

// ==== verification/tb_conditional_skip_test_instructions.sv ====
// self-checking bench for the conditional skip test core
`timescale 1ns/10ps
module tb_conditional_skip_test_instructions;
    logic       clk;
    logic       sys_rst;
    logic       instr_valid;
    logic [9:0] instr;
    logic       ext0_event;
    logic       conversion_event;
    logic       ext0_irq_enable_bit;
    logic       converter_irq_enable_bit;
    logic       irq_pin_polarity_bit;
    logic       irq_pin_level;
    logic       one_bit_port;
    logic       exec_enable;
    logic       skip_pending;
    logic       ext0_request_flag;
    logic       conversion_done_flag;
    int         err_total;
    int         samples_checked;

    cst_skip_core #(.INSTR_W(10)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
        .ext0_event(ext0_event), .conversion_event(conversion_event),
        .ext0_irq_enable_bit(ext0_irq_enable_bit), .converter_irq_enable_bit(converter_irq_enable_bit),
        .irq_pin_polarity_bit(irq_pin_polarity_bit), .irq_pin_level(irq_pin_level),
        .one_bit_port(one_bit_port), .exec_enable(exec_enable), .skip_pending(skip_pending),
        .ext0_request_flag(ext0_request_flag), .conversion_done_flag(conversion_done_flag)
    );

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    // 50 MHz instruction clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // issues one word, then leaves one idle cycle so gaps are exercised too
    task automatic issue(input logic [9:0] op, input logic exp_exec);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr       <= op;
        #1;
        check("exec_enable", exec_enable, exp_exec);
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic raise(input bit conv);
        @(posedge clk);
        if (conv) conversion_event <= 1'b1;
        else ext0_event <= 1'b1;
        @(posedge clk);
        conversion_event <= 1'b0;
        ext0_event       <= 1'b0;
        #1;
        check("flag set", conv ? conversion_done_flag : ext0_request_flag, 1'b1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // flag tests: enable set means no-operation, enable clear skips and clears
    task automatic test_flag(input bit conv);
        logic [9:0] op;
        op = conv ? cst_pkg::CST_OP_CONV_DONE : cst_pkg::CST_OP_EXT0_FLAG;
        @(posedge clk);
        if (conv) converter_irq_enable_bit <= 1'b1;
        else ext0_irq_enable_bit <= 1'b1;
        raise(conv);
        issue(op, 1'b1);
        check("nop skip", skip_pending, 1'b0);
        check("nop flag", conv ? conversion_done_flag : ext0_request_flag, 1'b1);
        @(posedge clk);
        if (conv) converter_irq_enable_bit <= 1'b0;
        else ext0_irq_enable_bit <= 1'b0;
        issue(op, 1'b1);
        check("taken skip", skip_pending, 1'b1);
        check("flag cleared", conv ? conversion_done_flag : ext0_request_flag, 1'b0);
        issue(10'h000, 1'b0);
        check("skip consumed", skip_pending, 1'b0);
        issue(op, 1'b1);
        check("clear flag no skip", skip_pending, 1'b0);
    endtask

    // port test for both port values
    task automatic test_port();
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            one_bit_port <= v[0];
            issue(cst_pkg::CST_OP_PORT_BIT, 1'b1);
            check("port skip", skip_pending, v[0]);
            if (v == 1) issue(10'h000, 1'b0);
        end
    endtask

    // pin test over every polarity and level pairing
    task automatic test_pin();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            irq_pin_polarity_bit <= k[1];
            irq_pin_level        <= k[0];
            issue(cst_pkg::CST_OP_PIN_LEVEL, 1'b1);
            check("pin skip", skip_pending, k[1] == k[0]);
            if (k[1] == k[0]) issue(10'h000, 1'b0);
        end
    endtask

    // a flag test that falls in a skipped slot must not clear its flag
    task automatic test_suppress();
        raise(1'b0);
        @(posedge clk);
        one_bit_port <= 1'b1;
        issue(cst_pkg::CST_OP_PORT_BIT, 1'b1);
        check("port skip", skip_pending, 1'b1);
        issue(cst_pkg::CST_OP_EXT0_FLAG, 1'b0);
        check("suppressed no skip", skip_pending, 1'b0);
        check("suppressed flag kept", ext0_request_flag, 1'b1);
        issue(cst_pkg::CST_OP_EXT0_FLAG, 1'b1);
        check("late skip", skip_pending, 1'b1);
        check("late clear", ext0_request_flag, 1'b0);
        issue(10'h000, 1'b0);
    endtask

    // request arriving on the cycle of a taken test keeps its flag set
    task automatic test_set_wins(input bit conv);
        raise(conv);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr       <= conv ? cst_pkg::CST_OP_CONV_DONE : cst_pkg::CST_OP_EXT0_FLAG;
        if (conv) conversion_event <= 1'b1;
        else ext0_event <= 1'b1;
        @(posedge clk);
        instr_valid      <= 1'b0;
        conversion_event <= 1'b0;
        ext0_event       <= 1'b0;
        #1;
        check("set wins skip", skip_pending, 1'b1);
        check("set wins flag", conv ? conversion_done_flag : ext0_request_flag, 1'b1);
        issue(10'h000, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    // all inputs defined at time zero, reset held for twelve cycles
    initial begin
        err_total = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr = 10'h000;
        ext0_event = 1'b0;
        conversion_event = 1'b0;
        ext0_irq_enable_bit = 1'b0;
        converter_irq_enable_bit = 1'b0;
        irq_pin_polarity_bit = 1'b0;
        irq_pin_level = 1'b1;
        one_bit_port = 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("reset skip", skip_pending, cst_pkg::CST_SKIP_RST);
        check("reset ext0 flag", ext0_request_flag, cst_pkg::CST_FLAG_RST);
        check("reset conv flag", conversion_done_flag, cst_pkg::CST_FLAG_RST);
        test_flag(1'b0);
        test_flag(1'b1);
        test_port();
        test_pin();
        test_suppress();
        test_set_wins(1'b0);
        test_set_wins(1'b1);
        finish_test();
    end
endmodule
